// ===== design/diag_irq_jump_consts.svh
// Offsets, opcodes, field positions and reset values of the decode block
`ifndef DIAG_IRQ_JUMP_CONSTS_SVH
`define DIAG_IRQ_JUMP_CONSTS_SVH
`define OFS_ENTRY0 9'h10A
`define OFS_ENTRY1 9'h10B
`define OFS_STATE0 9'h10F
`define OFS_STATE1 9'h110
`define OFS_ENTRY0_B2 9'h12A
`define OFS_ENTRY1_B2 9'h12B
`define OFS_STATE0_B2 9'h12F
`define OFS_STATE1_B2 9'h130
`define OFS_GRANT_A 9'h184
`define OFS_GRANT_B 9'h185
`define OFS_GRANT_C 9'h186
`define OFS_GRANT_D 9'h187
`define OFS_SETUP 9'h1C5
`define OFS_FAULTS 9'h1D2
`define SLOT_ENTRY 4'h0
`define SLOT_STATE 4'h2
`define SLOT_GRANT 4'h4
`define SLOT_SETUP 4'h8
`define SLOT_FAULTS 4'h9
`define SLOT_NONE 4'hF
`define RST_WORD 16'h0000
`define OP_DIAG_ALL 15'h1B00
`define OP_DIAG_ONE 11'h1A6
`define OP_DIAG_SC 8'h26
`define OP_RET_CONF 14'h0D81
`define OP_RET 14'h0D66
`define OP_JUMP_HI 7'h1D
`define OP_JUMP_LO 4'h5
`define COND_NO_SAT 4'hB
`define COND_POS_ONLY 4'hC
`define NUM_OUT 4'd12
`define NUM_HS 4'd5
`define SEL_LS_BASE 4'd10
`define LS_SHIFT 4'd5
`define ONE_OUT 12'h001
`define SRC_SEL_BIT 0
`define SRC_FAULT_BIT 12
`define ADDR_LSB 10
`endif

// ===== design/diag_irq_jump_pkg.sv
// Types shared by the decode block and its bench
package diag_irq_jump_pkg;
  typedef enum logic [1:0] {
    CONF_NONE = 2'b00,
    CONF_CONTINUE = 2'b01,
    CONF_RESTART = 2'b10
  } ret_conf_t;
  typedef enum logic [1:0] {
    FIELD_KEEP = 2'b00,
    FIELD_OFF = 2'b01,
    FIELD_ON = 2'b10
  } watch_field_t;
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } instr_t;
  typedef struct packed {
    logic load;
    logic [9:0] target;
    logic flush;
    logic done;
  } pc_req_t;
endpackage

// ===== design/diag_irq_jump.sv
// Microcore decode: diagnosis enables, interrupt return, far jumps
`timescale 1ns/100ps
`default_nettype none
`include "diag_irq_jump_consts.svh"
// =====================================================================
// Summary of operation
// - Global op switches diagnosis for all granted outputs
// - Only granted outputs change diagnosis state
// - Reset leaves every diagnosis disabled
// - Enabled fault raises error interrupt
// - Four shortcut events watched concurrently
// - Shortcut fields keep, off or on
// - Shortcut outputs come from shortcut definition
// - Config none ignores return requests
// - Config continue resumes interrupted code
// - Config restart resumes at entry address
// - Config resets to none; bits 1:0
// - Setup bit picks return request source
// - Return ends routine, clears interrupt state
// - Continue return uses state low ten bits
// - Restart return uses entry address register
// - Bit 0 flushes pending interrupt queue
// - True condition jumps to far target
// - Selector indexes ALU condition register
// - Selectors 11, 12 reflect arithmetic modes
// - Jump encoding: selector 8:5, register 4
// - Single-output op switches one feedback
module diag_irq_jump (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // Register port
  input wire logic [8:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // Instruction from code RAM
  input wire diag_irq_jump_pkg::instr_t INSTR,
  // Program counter side
  input wire logic CORE_SEL,
  input wire logic [9:0] FAR_TARGET_ONE,
  input wire logic [9:0] FAR_TARGET_TWO,
  output diag_irq_jump_pkg::pc_req_t PC_REQ,
  // ALU condition
  input wire logic [15:0] ALU_CONDITION,
  input wire logic SAT_ENABLED,
  input wire logic POSITIVE_ONLY,
  // Shortcuts and diagnosis feedback
  input wire logic [3:0] SC1_OUTPUT,
  input wire logic [3:0] SC2_OUTPUT,
  input wire logic [3:0] SC3_OUTPUT,
  input wire logic [11:0] VDS_FAULT,
  input wire logic [4:0] SRC_FAULT,
  output logic [11:0] VDS_WATCH,
  output logic [4:0] SRC_WATCH,
  output logic DIAG_IRQ,
  // Interrupt entry and return sources
  input wire logic IRQ_ENTER,
  input wire logic [15:0] IRQ_WORD,
  input wire logic DRIVERS_REENABLED
);
  import diag_irq_jump_pkg::*;

  // ===================================================================
  // Helpers
  function automatic logic [3:0] reg_slot(input logic [8:0] a);
    case (a)
      `OFS_ENTRY0, `OFS_ENTRY0_B2: reg_slot = `SLOT_ENTRY;
      `OFS_ENTRY1, `OFS_ENTRY1_B2: reg_slot = `SLOT_ENTRY + 4'h1;
      `OFS_STATE0, `OFS_STATE0_B2: reg_slot = `SLOT_STATE;
      `OFS_STATE1, `OFS_STATE1_B2: reg_slot = `SLOT_STATE + 4'h1;
      `OFS_GRANT_A: reg_slot = `SLOT_GRANT;
      `OFS_GRANT_B: reg_slot = `SLOT_GRANT + 4'h1;
      `OFS_GRANT_C: reg_slot = `SLOT_GRANT + 4'h2;
      `OFS_GRANT_D: reg_slot = `SLOT_GRANT + 4'h3;
      `OFS_SETUP: reg_slot = `SLOT_SETUP;
      `OFS_FAULTS: reg_slot = `SLOT_FAULTS;
      default: reg_slot = `SLOT_NONE;
    endcase
  endfunction
  function automatic logic [11:0] out_onehot(input logic [3:0] idx);
    out_onehot = (idx < `NUM_OUT) ? (`ONE_OUT << idx) : '0;
  endfunction
  function automatic logic field_next(input logic [1:0] f,
                                      input logic old,
                                      input logic ok);
    if (!ok)
      field_next = old;
    else if (f == FIELD_ON)
      field_next = 1'b1;
    else if (f == FIELD_OFF)
      field_next = 1'b0;
    else
      field_next = old;
  endfunction

  // ===================================================================
  // Registers
  logic [15:0] entry_q [2];
  logic [15:0] state_q [2];
  logic [15:0] grant_q [4];
  logic [15:0] setup_q;
  logic [15:0] flags_q;
  logic [15:0] rdata_q;
  logic [3:0] wslot;
  logic [3:0] rslot;
  logic [11:0] grant_out;
  logic faults_touched;

  assign wslot = reg_slot(REG_ADDR);
  assign rslot = wslot;
  // Grant A serves core 0 and grant B core 1; C and D are storage only
  assign grant_out = CORE_SEL ? grant_q[1][11:0] : grant_q[0][11:0];
  assign faults_touched = (REG_RD || REG_WR) && wslot == `SLOT_FAULTS;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      entry_q[0] <= `RST_WORD;
      entry_q[1] <= `RST_WORD;
      setup_q <= `RST_WORD;
      for (int i = 0; i < 4; i++) begin
        grant_q[i] <= `RST_WORD;
      end
    end else if (REG_WR) begin
      if (wslot[3:1] == `SLOT_ENTRY >> 1)
        entry_q[wslot[0]] <= REG_WDATA;
      if (wslot[3:2] == `SLOT_GRANT >> 2)
        grant_q[wslot[1:0]] <= REG_WDATA;
      if (wslot == `SLOT_SETUP)
        setup_q <= REG_WDATA;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rdata_q <= `RST_WORD;
    end else if (!REG_RD) begin
      rdata_q <= `RST_WORD;
    end else begin
      case (rslot)
        `SLOT_ENTRY, `SLOT_ENTRY + 4'h1: rdata_q <= entry_q[rslot[0]];
        `SLOT_STATE, `SLOT_STATE + 4'h1: rdata_q <= state_q[rslot[0]];
        `SLOT_SETUP: rdata_q <= setup_q;
        `SLOT_FAULTS: rdata_q <= flags_q;
        default: begin
          if (rslot[3:2] == `SLOT_GRANT >> 2)
            rdata_q <= grant_q[rslot[1:0]];
          else
            rdata_q <= `RST_WORD;
        end
      endcase
    end
  end
  assign REG_RDATA = rdata_q;

  // ===================================================================
  // Instruction decode
  logic [15:0] w;
  logic is_all;
  logic is_one;
  logic is_sc;
  logic is_conf;
  logic is_ret;
  logic is_jump;
  assign w = INSTR.word;
  assign is_all = INSTR.valid && w[15:1] == `OP_DIAG_ALL;
  assign is_one = INSTR.valid && w[15:5] == `OP_DIAG_ONE;
  assign is_sc = INSTR.valid && w[15:8] == `OP_DIAG_SC;
  assign is_conf = INSTR.valid && w[15:2] == `OP_RET_CONF;
  assign is_ret = INSTR.valid && w[15:2] == `OP_RET;
  assign is_jump = INSTR.valid && w[15:9] == `OP_JUMP_HI
                   && w[3:0] == `OP_JUMP_LO;

  // ===================================================================
  // Diagnosis enables
  logic [11:0] vds_en_q;
  logic [4:0] src_en_q;
  logic [3:0] sc_en_q;
  logic [3:0] one_out;
  logic one_src;
  logic [11:0] sc1_hot;
  logic [11:0] sc2_hot;
  logic [11:0] sc3_hot;
  logic [3:0] sc_ok;

  // Selectors below ten alternate drain-source and source of high sides
  assign one_src = w[4:1] < `SEL_LS_BASE && w[1];
  assign one_out = (w[4:1] < `SEL_LS_BASE) ? {1'b0, w[4:2]}
                                           : w[4:1] - `LS_SHIFT;
  assign sc1_hot = out_onehot(SC1_OUTPUT);
  assign sc2_hot = out_onehot(SC2_OUTPUT);
  assign sc3_hot = out_onehot(SC3_OUTPUT);
  assign sc_ok = {|(sc1_hot & grant_out),
                  |(sc1_hot[4:0] & grant_out[4:0]),
                  |(sc2_hot & grant_out),
                  |(sc3_hot & grant_out)};

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      vds_en_q <= '0;
      src_en_q <= '0;
    end else if (is_all) begin
      vds_en_q <= (vds_en_q & ~grant_out)
                  | ({12{w[0]}} & grant_out);
      src_en_q <= (src_en_q & ~grant_out[4:0])
                  | ({5{w[0]}} & grant_out[4:0]);
    end else if (is_one && grant_out[one_out]) begin
      if (one_src)
        src_en_q[one_out[2:0]] <= w[0];
      else
        vds_en_q[one_out] <= w[0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sc_en_q <= '0;
    end else if (is_sc) begin
      for (int f = 0; f < 4; f++) begin
        sc_en_q[f] <= field_next(w[2*f +: 2], sc_en_q[f], sc_ok[f]);
      end
    end
  end

  // Watches merge per-output and shortcut enables
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      VDS_WATCH <= '0;
      SRC_WATCH <= '0;
    end else begin
      VDS_WATCH <= vds_en_q | (sc1_hot & {12{sc_en_q[3]}})
                   | (sc2_hot & {12{sc_en_q[1]}})
                   | (sc3_hot & {12{sc_en_q[0]}});
      SRC_WATCH <= src_en_q | (sc1_hot[4:0] & {5{sc_en_q[2]}});
    end
  end

  // ===================================================================
  // Faults and interrupt
  logic vds_hit;
  logic src_hit;
  logic diag_wait_q;
  assign vds_hit = |(VDS_FAULT & VDS_WATCH);
  assign src_hit = |(SRC_FAULT & SRC_WATCH);

  always_ff @(posedge CLOCK) begin
    if (SRST)
      DIAG_IRQ <= 1'b0;
    else
      DIAG_IRQ <= vds_hit || src_hit;
  end

  // New faults win over a clearing access in the same cycle
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      flags_q <= `RST_WORD;
    end else begin
      flags_q <= faults_touched ? `RST_WORD : flags_q;
      flags_q[11:0] <= (faults_touched ? '0 : flags_q[11:0])
                       | (VDS_FAULT & VDS_WATCH);
      flags_q[`SRC_FAULT_BIT] <= (!faults_touched
                                  && flags_q[`SRC_FAULT_BIT]) || src_hit;
    end
  end

  // ===================================================================
  // Interrupt return
  ret_conf_t conf_q;
  logic ret_req;
  logic ret_fire;
  logic [9:0] resume_at;
  logic [9:0] entry_at;
  assign ret_req = setup_q[`SRC_SEL_BIT] ? (faults_touched && diag_wait_q)
                                         : DRIVERS_REENABLED;
  assign ret_fire = ret_req && conf_q != CONF_NONE;
  assign resume_at = state_q[CORE_SEL][`ADDR_LSB-1:0];
  assign entry_at = entry_q[CORE_SEL][`ADDR_LSB-1:0];

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      conf_q <= CONF_NONE;
    end else if (is_conf) begin
      unique case (w[1:0])
        CONF_CONTINUE: conf_q <= CONF_CONTINUE;
        CONF_RESTART: conf_q <= CONF_RESTART;
        default: conf_q <= CONF_NONE;
      endcase
    end
  end

  // Waiting flag tracks a diagnosis interrupt not yet answered
  always_ff @(posedge CLOCK) begin
    if (SRST)
      diag_wait_q <= 1'b0;
    else if (DIAG_IRQ)
      diag_wait_q <= 1'b1;
    else if (faults_touched)
      diag_wait_q <= 1'b0;
  end

  // Entry wins over a clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_q[0] <= `RST_WORD;
      state_q[1] <= `RST_WORD;
    end else if (IRQ_ENTER) begin
      state_q[CORE_SEL] <= IRQ_WORD;
    end else if (ret_fire || is_ret) begin
      state_q[CORE_SEL] <= `RST_WORD;
    end
  end

  // ===================================================================
  // Program counter requests
  logic [15:0] cond_vec;
  always_comb begin
    cond_vec = ALU_CONDITION;
    cond_vec[`COND_NO_SAT] = !SAT_ENABLED;
    cond_vec[`COND_POS_ONLY] = POSITIVE_ONLY;
  end

  // An automatic return outranks the instruction of the same cycle
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      PC_REQ <= '0;
    end else begin
      PC_REQ <= '0;
      if (ret_fire) begin
        PC_REQ.load <= 1'b1;
        PC_REQ.done <= 1'b1;
        PC_REQ.target <= (conf_q == CONF_RESTART) ? entry_at
                                                  : resume_at;
      end else if (is_ret) begin
        PC_REQ.load <= 1'b1;
        PC_REQ.done <= 1'b1;
        PC_REQ.flush <= w[0];
        PC_REQ.target <= w[1] ? resume_at : entry_at;
      end else if (is_jump && cond_vec[w[8:5]]) begin
        PC_REQ.load <= 1'b1;
        PC_REQ.target <= w[4] ? FAR_TARGET_TWO : FAR_TARGET_ONE;
      end
    end
  end

  // ===================================================================
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  sequence jump_true_s;
    is_jump && cond_vec[w[8:5]] && !ret_fire;
  endsequence
  sequence cont_ret_s;
    is_ret && w[1] && !ret_fire;
  endsequence
  jump_taken_a: assert property (jump_true_s |=> PC_REQ.load
    && PC_REQ.target == ($past(w[4]) ? $past(FAR_TARGET_TWO)
                                     : $past(FAR_TARGET_ONE)))
    else $error("far jump not taken");
  jump_skip_a: assert property (is_jump && !cond_vec[w[8:5]]
    && !ret_fire |=> !PC_REQ.load)
    else $error("jump taken on false condition");
  sat_select_a: assert property (is_jump && w[8:5] == `COND_NO_SAT
    && SAT_ENABLED && !ret_fire |=> !PC_REQ.load)
    else $error("saturation selector wrong");
  none_ignore_a: assert property (conf_q == CONF_NONE
    && !is_ret && !is_jump |=> !PC_REQ.load)
    else $error("return request not ignored");
  restart_ret_a: assert property (ret_req && conf_q == CONF_RESTART
    |=> PC_REQ.load && PC_REQ.target == $past(entry_at))
    else $error("restart return wrong target");
  cont_ret_a: assert property (cont_ret_s |=> PC_REQ.done
    && PC_REQ.target == $past(resume_at) && PC_REQ.flush == $past(w[0]))
    else $error("continue return wrong");
  state_clear_a: assert property (cont_ret_s and !IRQ_ENTER
    |=> state_q[$past(CORE_SEL)] == `RST_WORD)
    else $error("interrupt state not cleared");
  grant_guard_a: assert property (is_all && !grant_out[0]
    |=> vds_en_q[0] == $past(vds_en_q[0]))
    else $error("ungranted output changed");
  all_enable_a: assert property (is_all && w[0] && grant_out[1]
    |=> vds_en_q[1] ##1 VDS_WATCH[1])
    else $error("global enable missed");
  keep_field_a: assert property (is_sc && w[1:0] == FIELD_KEEP
    |=> $stable(sc_en_q[0]))
    else $error("keep field changed state");
  fault_irq_a: assert property (|(VDS_FAULT & VDS_WATCH)
    |=> DIAG_IRQ)
    else $error("fault did not interrupt");
  reset_off_a: assert property (disable iff (1'b0)
    $fell(SRST) |-> VDS_WATCH == '0 && SRC_WATCH == '0
    && conf_q == CONF_NONE)
    else $error("diagnosis on after reset");
endmodule
`default_nettype wire

// ===== verification/code_ram_model.sv
// Code RAM model that feeds instruction words to the decoder
`timescale 1ns/100ps
`default_nettype none
module code_ram_model (
  // Clock
  input wire logic clock,
  // Loader
  input wire logic wr_en,
  input wire logic [9:0] wr_addr,
  input wire logic [15:0] wr_word,
  // Fetch
  input wire logic fetch,
  output diag_irq_jump_pkg::instr_t instr
);
  import diag_irq_jump_pkg::*;
  logic [15:0] mem [0:1023];
  logic [15:0] last_q = 16'h0000;
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_word;
    end
    if (fetch) begin
      last_q <= mem[wr_addr];
    end
  end
  // Idle word is the inverse of the last one, so no stale value can match
  assign instr = fetch ? {1'b1, mem[wr_addr]} : {1'b0, ~last_q};
endmodule
`default_nettype wire

// ===== verification/tb_microcore_diag_irq_jump_ops.sv
// Self-checking bench for the microcore decode block
`timescale 1ns/100ps
`default_nettype none
module tb_microcore_diag_irq_jump_ops;
  import diag_irq_jump_pkg::*;
  typedef struct {
    logic [15:0] word;
    logic [15:0] alu;
    logic sat;
    logic pos;
    pc_req_t pc;
  } row_t;
  localparam logic [9:0] T1 = 10'h155;
  localparam logic [9:0] T2 = 10'h2AA;
  logic clock, srst, reg_wr, reg_rd, core_sel, sat_en, pos_only, reen;
  logic irq_enter, wr_en, fetch, diag_irq;
  logic [8:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, alu, irq_word, wr_word;
  logic [9:0] wr_addr;
  logic [3:0] sc1, sc2, sc3;
  logic [11:0] vds_fault, vds_watch;
  logic [4:0] src_fault, src_watch;
  instr_t instr;
  pc_req_t pc;
  int fail_count, samples_checked;
  row_t rows [8];
  logic [8:0] ofs [15];

  // =====================================================================
  // Design and partner
  diag_irq_jump uut (.CLOCK(clock), .SRST(srst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .INSTR(instr), .CORE_SEL(core_sel),
    .FAR_TARGET_ONE(T1), .FAR_TARGET_TWO(T2), .PC_REQ(pc),
    .ALU_CONDITION(alu), .SAT_ENABLED(sat_en), .POSITIVE_ONLY(pos_only),
    .SC1_OUTPUT(sc1), .SC2_OUTPUT(sc2), .SC3_OUTPUT(sc3),
    .VDS_FAULT(vds_fault), .SRC_FAULT(src_fault), .VDS_WATCH(vds_watch),
    .SRC_WATCH(src_watch), .DIAG_IRQ(diag_irq), .IRQ_ENTER(irq_enter),
    .IRQ_WORD(irq_word), .DRIVERS_REENABLED(reen));
  code_ram_model ram (.clock(clock), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_word(wr_word), .fetch(fetch), .instr(instr));

  // =====================================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pc(input pc_req_t exp);
    chk({3'b000, pc}, {3'b000, exp});
  endtask
  function automatic pc_req_t pq(logic [9:0] t, logic f, logic d);
    return '{1'b1, t, f, d};
  endfunction
  function automatic logic [15:0] jw(logic [3:0] s, logic r);
    return 16'h3A05 | {7'h00, s, r, 4'h0};
  endfunction
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Two cycles per instruction: load the word, then fetch it
  task automatic exec(input logic [15:0] w);
    @(posedge clock);
    wr_en <= 1'b1;
    wr_addr <= 10'h003;
    wr_word <= w;
    @(posedge clock);
    wr_en <= 1'b0;
    fetch <= 1'b1;
    @(posedge clock);
    fetch <= 1'b0;
    #1;
  endtask
  task automatic watch(input logic [11:0] v, input logic [4:0] s);
    @(posedge clock);
    #1 chk({4'h0, vds_watch}, {4'h0, v});
    chk({11'h000, src_watch}, {11'h000, s});
  endtask
  task automatic pulse_reen;
    @(posedge clock);
    reen <= 1'b1;
    @(posedge clock);
    reen <= 1'b0;
    #1;
  endtask
  task automatic enter(input logic [15:0] w);
    @(posedge clock);
    irq_enter <= 1'b1;
    irq_word <= w;
    @(posedge clock);
    irq_enter <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // =====================================================================
  // Clock and watchdog
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end

  // =====================================================================
  // Main sequence
  initial begin
    {srst, reg_wr, reg_rd, core_sel, sat_en, pos_only, reen} = 7'h01 << 6;
    {irq_enter, wr_en, fetch, reg_addr, wr_addr} = '0;
    {reg_wdata, alu, irq_word, wr_word, vds_fault, src_fault} = '0;
    sc1 = 4'h2;
    sc2 = 4'h7;
    sc3 = 4'hB;
    fail_count = 0;
    samples_checked = 0;
    ofs = '{9'h10A, 9'h10B, 9'h10F, 9'h110, 9'h12A, 9'h12B, 9'h12F,
      9'h130, 9'h184, 9'h185, 9'h186, 9'h187, 9'h1C5, 9'h1D2, 9'h100};
    rows[0] = '{jw(4'h6, 1'b0), 16'h0040, 1'b1, 1'b0, pq(T1, 1'b0, 1'b0)};
    rows[1] = '{jw(4'h6, 1'b0), 16'hFFBF, 1'b1, 1'b0, '0};
    rows[2] = '{jw(4'hB, 1'b1), 16'h0000, 1'b0, 1'b0, pq(T2, 1'b0, 1'b0)};
    rows[3] = '{jw(4'hB, 1'b0), 16'hFFFF, 1'b1, 1'b0, '0};
    rows[4] = '{jw(4'hC, 1'b0), 16'h0000, 1'b1, 1'b1, pq(T1, 1'b0, 1'b0)};
    rows[5] = '{jw(4'hC, 1'b0), 16'hFFFF, 1'b1, 1'b0, '0};
    rows[6] = '{jw(4'hF, 1'b1), 16'h8000, 1'b1, 1'b0, pq(T2, 1'b0, 1'b0)};
    rows[7] = '{16'h3A04, 16'hFFFF, 1'b0, 1'b1, '0};
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    #1 chk({4'h0, vds_watch}, 16'h0000);
    chk({11'h000, src_watch}, 16'h0000);
    foreach (ofs[i]) rd(ofs[i], 16'h0000);
    pulse_reen();
    chk_pc('0);
    // Jump table rows
    foreach (rows[i]) begin
      @(posedge clock);
      alu <= rows[i].alu;
      sat_en <= rows[i].sat;
      pos_only <= rows[i].pos;
      exec(rows[i].word);
      chk_pc(rows[i].pc);
      @(posedge clock);
      #1 chk_pc('0);
    end
    // Sweep of the plain flag selectors, true then false
    sat_en <= 1'b1;
    pos_only <= 1'b0;
    for (int s = 0; s < 16; s++) begin
      if (s != 11 && s != 12) begin
        alu <= 16'h0001 << s;
        exec(jw(4'(s), s[0]));
        chk_pc(pq(s[0] ? T2 : T1, 1'b0, 1'b0));
        alu <= ~(16'h0001 << s);
        exec(jw(4'(s), s[0]));
        chk_pc('0);
      end
    end
    // Registers: read back and strobe width
    wr(9'h186, 16'hA5C3);
    rd(9'h186, 16'hA5C3);
    @(posedge clock);
    #1 chk(reg_rdata, 16'h0000);
    // Global and single-output diagnosis under grants
    wr(9'h184, 16'h0FFF);
    exec(16'h3601);
    watch(12'hFFF, 5'h1F);
    wr(9'h184, 16'h000F);
    exec(16'h3600);
    watch(12'hFF0, 5'h10);
    wr(9'h184, 16'h0FFF);
    watch(12'hFF0, 5'h10);
    core_sel <= 1'b1;
    exec(16'h3601);
    watch(12'hFF0, 5'h10);
    wr(9'h185, 16'h0003);
    exec(16'h3601);
    watch(12'hFF3, 5'h13);
    core_sel <= 1'b0;
    exec(16'h3600);
    watch(12'h000, 5'h00);
    exec(16'h34CF);
    exec(16'h34D9);
    watch(12'h080, 5'h08);
    exec(16'h3600);
    // Shortcut diagnosis fields
    exec(16'h26AA);
    watch(12'h884, 5'h04);
    exec(16'h2610);
    watch(12'h884, 5'h00);
    exec(16'h26FF);
    watch(12'h884, 5'h00);
    exec(16'h2641);
    exec(16'h3600);
    watch(12'h080, 5'h00);
    sc2 <= 4'h9;
    @(posedge clock);
    watch(12'h200, 5'h00);
    vds_fault <= 12'hDFF;
    repeat (2) @(posedge clock);
    #1 chk({15'h0000, diag_irq}, 16'h0000);
    vds_fault <= 12'h200;
    repeat (2) @(posedge clock);
    #1 chk({15'h0000, diag_irq}, 16'h0001);
    vds_fault <= 12'h000;
    // Interrupt return by the re-enable source
    exec(16'h3605);
    enter(16'h8123);
    rd(9'h12F, 16'h8123);
    wr(9'h10F, 16'h0000);
    rd(9'h10F, 16'h8123);
    pulse_reen();
    chk_pc(pq(10'h123, 1'b0, 1'b1));
    rd(9'h10F, 16'h0000);
    wr(9'h10A, 16'h0277);
    exec(16'h3606);
    enter(16'h8050);
    pulse_reen();
    chk_pc(pq(10'h277, 1'b0, 1'b1));
    // Status access as return source; flags read clears them
    wr(9'h1C5, 16'h0001);
    enter(16'h0099);
    pulse_reen();
    chk_pc('0);
    rd(9'h1D2, 16'h0200);
    chk_pc(pq(10'h277, 1'b0, 1'b1));
    exec(16'h3604);
    enter(16'h0044);
    rd(9'h1D2, 16'h0000);
    chk_pc('0);
    // Return instruction
    enter(16'h83C5);
    exec(16'h359A);
    chk_pc(pq(10'h3C5, 1'b0, 1'b1));
    rd(9'h10F, 16'h0000);
    exec(16'h3599);
    chk_pc(pq(10'h277, 1'b1, 1'b1));
    core_sel <= 1'b1;
    wr(9'h12B, 16'h0101);
    rd(9'h10B, 16'h0101);
    exec(16'h3598);
    chk_pc(pq(10'h101, 1'b0, 1'b1));
    // Reset in mid-run must drop every enable and the return config
    exec(16'h3601);
    exec(16'h3605);
    watch(12'h203, 5'h03);
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    watch(12'h000, 5'h00);
    pulse_reen();
    chk_pc('0);
    print_verdict();
  end
endmodule
`default_nettype wire
